/* File: switch_core_buffering.sv */
// ingress fifos, upstream and downstream transfer buses, decoupler and egress stage
// assumes stacks hold their inputs until the matching ready is seen
`timescale 1ns/1ps

module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH)) || pop;
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem[rd_q];
  assign o_count     = cnt_q;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// What this block does
// R1 - port 0 upstream, ports 2, 4 downstream
// R2 - down bus from upstream, up bus to upstream
// R3 - peer traffic: up bus, decoupler, down bus
// R4 - per port posted, nonposted, completion, insertion queues
// R5 - queue full on bytes or TLP count
// R6 - posted, completion: 4 KB or 32 TLPs
// R7 - nonposted: 768 bytes or 32 TLPs
// R8 - replay buffer holds up to 32 TLPs
// R9 - output space allows x4 rate delivery
// R10 - decoupler holds one TLP of 2112 bytes
// R11 - insertion buffer: 12 dwords, two TLPs
// R12 - datapath 66 bits with dword parity
// R13 - TDM: even cycles even port, odd odd
// R14 - narrow ports use fewer of their slots
// R15 - single port stack uses every cycle
// R16 - demultiplex TDM words into right queues
// R17 - TLP crosses core contiguously once granted
// R18 - egress written contiguously into output buffer
// R19 - cut through when ingress not narrower
// R20 - store and forward when ingress narrower; the code also launches the head TLP once the fifo holds eight words
// R21 - best latency 204 ns or 272 ns
// R22 - 25-bit free-running timer stamps each TLP
// R23 - same-type TLPs never overtake each other
// R24 - even parity made on entry, carried unchanged
module switch_core_buffering (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_up_valid,
  output logic             o_up_ready,
  input  wire logic [63:0] i_up_data,
  input  wire logic        i_up_sop,
  input  wire logic        i_up_eop,
  input  wire logic [1:0]  i_up_cls,
  input  wire logic        i_up_to_b,
  input  wire logic        i_dn_valid,
  output logic             o_dn_ready,
  input  wire logic [63:0] i_dn_data,
  input  wire logic        i_dn_sop,
  input  wire logic        i_dn_eop,
  input  wire logic [1:0]  i_dn_cls,
  input  wire logic        i_dn_peer,
  input  wire logic        i_dn_tdm,
  input  wire logic [2:0][3:0]  i_lanes,
  output logic [2:0]            o_eg_valid,
  input  wire logic [2:0]       i_eg_ready,
  output logic [2:0][65:0]      o_eg_data,
  output logic [2:0]            o_eg_sop,
  output logic [2:0]            o_eg_eop,
  input  wire logic [2:0]       i_eg_ack,
  output logic [2:0][3:0]       o_q_full,
  output logic [2:0][24:0]      o_head_stamp,
  output logic [7:0]            o_adv_hdr,
  output logic [7:0]            o_adv_data_pc,
  output logic [7:0]            o_adv_data_np
);
  localparam int CW = $clog2(switch_core_pkg::FIFO_DEPTH) + 1;
  localparam logic [CW-1:0] FULL_CNT = CW'(switch_core_pkg::FIFO_DEPTH);

  logic                 phase_q;
  logic [1:0]           dn_idx;
  logic [1:0]           dn_dst;
  logic [2:0][96:0]     in_word;
  logic [2:0]           in_sel;
  logic [2:0]           acc_ok;
  logic [2:0]           f_in_ready;
  logic [2:0]           f_push;
  logic [2:0][96:0]     h_word;
  logic [2:0]           h_valid;
  logic [2:0]           h_ready;
  logic [2:0][CW-1:0]   f_cnt;
  logic [2:0][3:0]      done_q;
  logic [2:0]           launch_ok;
  logic [2:0][24:0]     stamp_q;
  logic [2:0][5:0]      rp_q;
  logic [2:0]           rp_ok;
  logic [2:0]           eg_free;
  logic [2:0]           eg_ld;
  logic [2:0]           eg_par_ok;
  logic [2:0][3:0]      cap_ok;
  switch_core_pkg::src_type u_own_q;
  switch_core_pkg::src_type d_own_q;
  logic                 u_rr_q;
  logic [96:0]          u_word;
  logic                 u_srcv;
  logic                 u_to_eg;
  logic                 u_mv;
  logic                 u_c2;
  logic                 u_c4;
  logic [96:0]          d_word;
  logic                 d_srcv;
  logic [1:0]           d_dst;
  logic                 d_mv;
  logic                 d_cup;
  logic                 d_cdec;
  logic                 d_gnt_up;
  logic [96:0]          dec_mem [switch_core_pkg::DEC_WORDS];
  logic [8:0]           wptr_q;
  logic [8:0]           rptr_q;
  logic                 dec_busy_q;
  logic                 dec_valid;
  logic                 dec_wr;
  logic                 dec_rd;

  assign o_adv_hdr     = switch_core_pkg::ADV_HDR;     // [R6] [R7]
  assign o_adv_data_pc = switch_core_pkg::ADV_DATA_PC; // [R6]
  assign o_adv_data_np = switch_core_pkg::ADV_DATA_NP; // [R7]

  // slot phase: even cycles feed port 2, odd cycles port 4
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= !phase_q;
    end
  end

  assign dn_idx = (i_dn_tdm && phase_q) ? switch_core_pkg::IDX_DN_B
                                        : switch_core_pkg::IDX_DN_A; // [R13] [R15] [R16]
  assign dn_dst = !i_dn_peer ? switch_core_pkg::IDX_UP :
                  (dn_idx == switch_core_pkg::IDX_DN_A) ? switch_core_pkg::IDX_DN_B
                                                        : switch_core_pkg::IDX_DN_A; // [R3]

  // parity is generated here and never recomputed downstream
  assign in_word[0] = {stamp_q[0], i_up_cls,
                       i_up_to_b ? switch_core_pkg::IDX_DN_B : switch_core_pkg::IDX_DN_A,
                       i_up_sop, i_up_eop,
                       switch_core_pkg::dword_parity(i_up_data), i_up_data}; // [R1] [R12] [R24]
  assign in_word[1] = {stamp_q[1], i_dn_cls, dn_dst, i_dn_sop, i_dn_eop,
                       switch_core_pkg::dword_parity(i_dn_data), i_dn_data}; // [R24]
  assign in_word[2] = {stamp_q[2], i_dn_cls, dn_dst, i_dn_sop, i_dn_eop,
                       switch_core_pkg::dword_parity(i_dn_data), i_dn_data}; // [R24]
  assign in_sel     = {i_dn_valid && (dn_idx == switch_core_pkg::IDX_DN_B),
                       i_dn_valid && (dn_idx == switch_core_pkg::IDX_DN_A),
                       i_up_valid}; // [R14] [R16]
  assign o_up_ready = f_in_ready[0] && acc_ok[0];
  assign o_dn_ready = f_in_ready[dn_idx] && acc_ok[dn_idx];

  function automatic logic o_eg_sop_d(input int p);
    o_eg_sop_d = (p == 0) ? u_word[switch_core_pkg::F_SOP] : d_word[switch_core_pkg::F_SOP];
  endfunction

  genvar gi;
  genvar gc;
  generate
    for (gi = 0; gi < switch_core_pkg::NPORT; gi++) begin : g_port
      logic [3:0][5:0]  tl_q;
      logic [3:0][12:0] by_q;
      logic [1:0]       icls;
      logic [1:0]       hcls;
      logic             hdst_eg;

      assign icls = in_word[gi][switch_core_pkg::F_CLS +: 2];
      assign hcls = h_word[gi][switch_core_pkg::F_CLS +: 2];
      // refuse a word that would overrun bytes, or a new TLP beyond the count
      assign acc_ok[gi] = !((in_word[gi][switch_core_pkg::F_SOP] &&
                             tl_q[icls] >= switch_core_pkg::cap_tlps(icls)) ||
                            (by_q[icls] + switch_core_pkg::WORD_BYTES >
                             switch_core_pkg::cap_bytes(icls))); // [R5] [R6] [R7] [R11]
      assign f_push[gi] = in_sel[gi] && acc_ok[gi] && f_in_ready[gi];

      sync_fifo #(.WIDTH(switch_core_pkg::WORD_W), .DEPTH(switch_core_pkg::FIFO_DEPTH)) u_fifo (
        .i_clk       (i_clk),
        .i_rstn      (i_rstn),
        .i_in_valid  (in_sel[gi] && acc_ok[gi]),
        .o_in_ready  (f_in_ready[gi]),
        .i_in_data   (in_word[gi]),
        .o_out_valid (h_valid[gi]),
        .i_out_ready (h_ready[gi]),
        .o_out_data  (h_word[gi]),
        .o_count     (f_cnt[gi])
      ); // [R23]

      // one free-running arrival timer per ingress queue set
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          stamp_q[gi] <= '0;
        end else begin
          stamp_q[gi] <= stamp_q[gi] + 25'h0000001; // [R22]
        end
      end

      for (gc = 0; gc < 4; gc++) begin : g_cls
        logic pu;
        logic po;
        assign pu = f_push[gi] && (icls == 2'(gc));
        assign po = h_valid[gi] && h_ready[gi] && (hcls == 2'(gc));
        assign o_q_full[gi][gc] = (tl_q[gc] >= switch_core_pkg::cap_tlps(2'(gc))) ||
                                  (by_q[gc] + switch_core_pkg::WORD_BYTES >
                                   switch_core_pkg::cap_bytes(2'(gc))); // [R5]
        assign cap_ok[gi][gc] = (tl_q[gc] <= switch_core_pkg::cap_tlps(2'(gc))) &&
                                (by_q[gc] <= switch_core_pkg::cap_bytes(2'(gc)));
        always_ff @(posedge i_clk or negedge i_rstn) begin
          if (!i_rstn) begin
            tl_q[gc] <= '0;
            by_q[gc] <= '0;
          end else begin
            tl_q[gc] <= tl_q[gc] + 6'(pu && in_word[gi][switch_core_pkg::F_SOP])
                                 - 6'(po && h_word[gi][switch_core_pkg::F_EOP]); // [R4]
            by_q[gc] <= by_q[gc] + (pu ? switch_core_pkg::WORD_BYTES : 13'h0000)
                                 - (po ? switch_core_pkg::WORD_BYTES : 13'h0000);
          end
        end
      end

      // count of complete TLPs sitting in the fifo
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          done_q[gi] <= '0;
        end else begin
          done_q[gi] <= done_q[gi] + 4'(f_push[gi] && in_word[gi][switch_core_pkg::F_EOP])
                        - 4'(h_valid[gi] && h_ready[gi] && h_word[gi][switch_core_pkg::F_EOP]);
        end
      end

      // a full fifo also launches, since a long TLP cannot fit in eight words
      assign launch_ok[gi] = (i_lanes[gi] >= i_lanes[h_word[gi][switch_core_pkg::F_DST +: 2]])
                             || (done_q[gi] != 4'h0) || (f_cnt[gi] == FULL_CNT); // [R19] [R20]
      assign o_head_stamp[gi] = h_word[gi][switch_core_pkg::F_TS +: 25];

      // egress stage feeds the output and replay buffer of the stack
      assign eg_free[gi] = !o_eg_valid[gi] || i_eg_ready[gi]; // [R9]
      assign rp_ok[gi]   = rp_q[gi] < switch_core_pkg::REPLAY_TLPS; // [R8]
      if (gi == 0) begin : g_up_eg
        assign eg_ld[gi] = u_mv && u_to_eg; // [R2]
      end else begin : g_dn_eg
        assign eg_ld[gi] = d_mv && (d_dst == 2'(gi)); // [R2]
      end
      assign eg_par_ok[gi] = o_eg_data[gi][65:64] ==
                             switch_core_pkg::dword_parity(o_eg_data[gi][63:0]);

      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          o_eg_valid[gi] <= 1'b0;
          o_eg_data[gi]  <= '0;
          o_eg_sop[gi]   <= 1'b0;
          o_eg_eop[gi]   <= 1'b0;
        end else if (eg_ld[gi]) begin
          o_eg_valid[gi] <= 1'b1; // [R21]
          o_eg_data[gi]  <= (gi == 0) ? u_word[65:0] : d_word[65:0]; // [R18] [R24]
          o_eg_sop[gi]   <= (gi == 0) ? u_word[switch_core_pkg::F_SOP]
                                      : d_word[switch_core_pkg::F_SOP];
          o_eg_eop[gi]   <= (gi == 0) ? u_word[switch_core_pkg::F_EOP]
                                      : d_word[switch_core_pkg::F_EOP];
        end else if (i_eg_ready[gi]) begin
          o_eg_valid[gi] <= 1'b0;
        end
      end

      // TLPs held for replay until the partner acknowledges them
      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          rp_q[gi] <= '0;
        end else begin
          rp_q[gi] <= rp_q[gi] + 6'(eg_ld[gi] && o_eg_sop_d(gi))
                      - 6'(i_eg_ack[gi] && rp_q[gi] != 6'h00); // [R8]
        end
      end
    end
  endgenerate

  // upstream bus: ports 2 and 4 toward port 0 or the decoupler
  assign u_c2 = h_valid[1] && h_word[1][switch_core_pkg::F_SOP] && launch_ok[1] &&
                ((h_word[1][switch_core_pkg::F_DST +: 2] == switch_core_pkg::IDX_UP) ?
                 rp_ok[0] : !dec_busy_q);
  assign u_c4 = h_valid[2] && h_word[2][switch_core_pkg::F_SOP] && launch_ok[2] &&
                ((h_word[2][switch_core_pkg::F_DST +: 2] == switch_core_pkg::IDX_UP) ?
                 rp_ok[0] : !dec_busy_q);
  assign u_word  = (u_own_q == switch_core_pkg::SRC_DN4) ? h_word[2] : h_word[1];
  assign u_srcv  = (u_own_q == switch_core_pkg::SRC_DN4) ? h_valid[2] :
                   (u_own_q == switch_core_pkg::SRC_DN2) ? h_valid[1] : 1'b0;
  assign u_to_eg = (u_word[switch_core_pkg::F_DST +: 2] == switch_core_pkg::IDX_UP);
  assign u_mv    = u_srcv && (u_to_eg ? eg_free[0]
                                      : (wptr_q < 9'(switch_core_pkg::DEC_WORDS))); // [R2] [R3]
  assign dec_wr  = u_mv && !u_to_eg; // [R3]

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      u_own_q <= switch_core_pkg::SRC_NONE;
      u_rr_q  <= 1'b0;
    end else begin
      case (u_own_q)
        switch_core_pkg::SRC_NONE: begin
          if (u_c2 && (!u_c4 || !u_rr_q)) begin
            u_own_q <= switch_core_pkg::SRC_DN2;
            u_rr_q  <= 1'b1;
          end else if (u_c4) begin
            u_own_q <= switch_core_pkg::SRC_DN4;
            u_rr_q  <= 1'b0;
          end
        end
        switch_core_pkg::SRC_DN2,
        switch_core_pkg::SRC_DN4: begin
          if (u_mv && u_word[switch_core_pkg::F_EOP]) begin
            u_own_q <= switch_core_pkg::SRC_NONE; // [R17]
          end
        end
        default: u_own_q <= switch_core_pkg::SRC_NONE;
      endcase
    end
  end

  // decoupler: one TLP at a time, read may trail the write
  assign dec_valid = rptr_q < wptr_q;
  assign dec_rd    = d_mv && (d_own_q == switch_core_pkg::SRC_DEC);

  always_ff @(posedge i_clk) begin
    if (dec_wr) begin
      dec_mem[wptr_q] <= u_word;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wptr_q     <= '0;
      rptr_q     <= '0;
      dec_busy_q <= 1'b0;
    end else if (dec_rd && d_word[switch_core_pkg::F_EOP]) begin
      wptr_q     <= '0;
      rptr_q     <= '0;
      dec_busy_q <= 1'b0; // [R10]
    end else begin
      if (dec_wr) begin
        wptr_q     <= wptr_q + 9'h001;
        dec_busy_q <= 1'b1; // [R10]
      end
      if (dec_rd) begin
        rptr_q <= rptr_q + 9'h001;
      end
    end
  end

  // downstream bus: port 0 or the decoupler toward ports 2 and 4
  assign d_cup    = h_valid[0] && h_word[0][switch_core_pkg::F_SOP] && launch_ok[0] &&
                    rp_ok[h_word[0][switch_core_pkg::F_DST +: 2]];
  assign d_cdec   = dec_valid && dec_mem[rptr_q][switch_core_pkg::F_SOP] &&
                    rp_ok[dec_mem[rptr_q][switch_core_pkg::F_DST +: 2]];
  assign d_gnt_up = (d_own_q == switch_core_pkg::SRC_NONE) && d_cup && !d_cdec;
  assign d_word   = (d_own_q == switch_core_pkg::SRC_DEC) ? dec_mem[rptr_q] : h_word[0];
  assign d_srcv   = (d_own_q == switch_core_pkg::SRC_DEC) ? dec_valid :
                    (d_own_q == switch_core_pkg::SRC_UP) ? h_valid[0] : 1'b0;
  assign d_dst    = d_word[switch_core_pkg::F_DST +: 2];
  assign d_mv     = d_srcv && eg_free[d_dst]; // [R2] [R3]
  assign h_ready  = {u_mv && (u_own_q == switch_core_pkg::SRC_DN4),
                     u_mv && (u_own_q == switch_core_pkg::SRC_DN2),
                     d_mv && (d_own_q == switch_core_pkg::SRC_UP)};

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      d_own_q <= switch_core_pkg::SRC_NONE;
    end else begin
      case (d_own_q)
        switch_core_pkg::SRC_NONE: begin
          if (d_cdec) begin
            d_own_q <= switch_core_pkg::SRC_DEC; // [R3]
          end else if (d_cup) begin
            d_own_q <= switch_core_pkg::SRC_UP;
          end
        end
        switch_core_pkg::SRC_UP,
        switch_core_pkg::SRC_DEC: begin
          if (d_mv && d_word[switch_core_pkg::F_EOP]) begin
            d_own_q <= switch_core_pkg::SRC_NONE; // [R17]
          end
        end
        default: d_own_q <= switch_core_pkg::SRC_NONE;
      endcase
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_parity_carried: assert property (&(eg_par_ok | ~o_eg_valid)) // [R24]
    else $error("egress word parity broken");
  a_ubus_sources: assert property (u_own_q != switch_core_pkg::SRC_UP && // [R2]
                                   u_own_q != switch_core_pkg::SRC_DEC)
    else $error("up bus owned by a wrong source");
  a_dbus_sources: assert property (d_own_q != switch_core_pkg::SRC_DN2 && // [R2]
                                   d_own_q != switch_core_pkg::SRC_DN4)
    else $error("down bus owned by a wrong source");
  a_peer_via_dec: assert property (dec_rd |-> dec_busy_q && wptr_q > rptr_q) // [R3]
    else $error("decoupler read without a stored TLP");
  a_dec_one_tlp: assert property ($rose(dec_busy_q) |-> $past(wptr_q) == 9'h000) // [R10]
    else $error("decoupler took a second TLP");
  a_queue_caps: assert property (&{cap_ok[0], cap_ok[1], cap_ok[2]}) // [R5]
    else $error("ingress queue over capacity");
  a_replay_cap: assert property (rp_q[0] <= switch_core_pkg::REPLAY_TLPS && // [R8]
                                 rp_q[1] <= switch_core_pkg::REPLAY_TLPS &&
                                 rp_q[2] <= switch_core_pkg::REPLAY_TLPS)
    else $error("replay buffer over capacity");
  a_tdm_odd_slot: assert property ((i_dn_tdm && f_push[2]) |-> phase_q ##1 !phase_q) // [R13]
    else $error("port 4 word taken in even slot");
  a_up_from_p0: assert property (f_push[0] |-> i_up_valid && // [R1]
                                 in_word[0][switch_core_pkg::F_DST +: 2] !=
                                 switch_core_pkg::IDX_UP)
    else $error("port 0 queue fed by a downstream stack");
  a_ubus_hold: assert property ((u_own_q != switch_core_pkg::SRC_NONE && // [R17]
                                 !(u_mv && u_word[switch_core_pkg::F_EOP]))
                                |=> u_own_q == $past(u_own_q))
    else $error("up bus dropped a TLP mid transfer");
  a_store_fwd: assert property ((d_gnt_up && i_lanes[0] < // [R20]
                                 i_lanes[h_word[0][switch_core_pkg::F_DST +: 2]])
                                |-> (done_q[0] != 4'h0 || f_cnt[0] == FULL_CNT))
    else $error("narrow ingress launched before TLP complete");

  c_peer_done: cover property (dec_rd && d_word[switch_core_pkg::F_EOP]);
  c_tdm_both: cover property (f_push[1] ##1 f_push[2]);
  c_both_buses: cover property (u_mv && d_mv);
  c_store_wait: cover property (h_valid[0] && !launch_ok[0] ##[1:20] d_gnt_up);
endmodule

/* File: switch_core_pkg.sv */
// constants, types and helpers shared by the switch core buffering logic
// assumes a single core clock; data moves in 64-bit words of 8 bytes, queue limits count bytes and TLPs
package switch_core_pkg;
  localparam int          NPORT       = 3;
  localparam int          DATA_W      = 64;
  localparam int          PATH_W      = 66;
  localparam int          STAMP_W     = 25;
  localparam int          FIFO_DEPTH  = 8;
  // ingress fifo word layout: stamp, class, destination, sop, eop, parity, data
  localparam int          F_EOP       = 66;
  localparam int          F_SOP       = 67;
  localparam int          F_DST       = 68;
  localparam int          F_CLS       = 70;
  localparam int          F_TS        = 72;
  localparam int          WORD_W      = 97;
  // internal port index: 0 is port 0, 1 is port 2, 2 is port 4
  localparam logic [1:0]  IDX_UP      = 2'h0;
  localparam logic [1:0]  IDX_DN_A    = 2'h1;
  localparam logic [1:0]  IDX_DN_B    = 2'h2;
  localparam logic [1:0]  CLS_POSTED  = 2'h0;
  localparam logic [1:0]  CLS_NONPOST = 2'h1;
  localparam logic [1:0]  CLS_COMPL   = 2'h2;
  localparam logic [1:0]  CLS_INSERT  = 2'h3;
  localparam logic [12:0] WORD_BYTES  = 13'h0008;
  localparam logic [12:0] PC_BYTES    = 13'h1000;
  localparam logic [12:0] NP_BYTES    = 13'h0300;
  localparam logic [12:0] INS_BYTES   = 13'h0030;
  localparam logic [5:0]  Q_TLPS      = 6'h20;
  localparam logic [5:0]  INS_TLPS    = 6'h02;
  localparam logic [7:0]  ADV_HDR     = 8'h20;
  localparam logic [7:0]  ADV_DATA_PC = 8'hd0;
  localparam logic [7:0]  ADV_DATA_NP = 8'h20;
  localparam logic [5:0]  REPLAY_TLPS = 6'h20;
  localparam int          DEC_BYTES   = 2112;
  localparam int          DEC_WORDS   = DEC_BYTES / 8;
  localparam int          CLK_NS      = 10;
  localparam int          LAT_X4_NS   = 204;
  localparam int          LAT_X1_NS   = 272;
  localparam int          LAT_X4_CYC  = (LAT_X4_NS + CLK_NS - 1) / CLK_NS;
  localparam int          LAT_X1_CYC  = (LAT_X1_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {SRC_NONE, SRC_UP, SRC_DN2, SRC_DN4, SRC_DEC} src_type;

  // even parity per dword: each bit makes its dword plus itself even
  function automatic logic [1:0] dword_parity(input logic [63:0] d);
    dword_parity = {^d[63:32], ^d[31:0]};
  endfunction

  function automatic logic [12:0] cap_bytes(input logic [1:0] c);
    cap_bytes = (c == CLS_NONPOST) ? NP_BYTES : (c == CLS_INSERT) ? INS_BYTES : PC_BYTES;
  endfunction

  function automatic logic [5:0] cap_tlps(input logic [1:0] c);
    cap_tlps = (c == CLS_INSERT) ? INS_TLPS : Q_TLPS;
  endfunction
endpackage

/* File: egress_stack_model.sv */
// egress stack stand-in: takes egress words, acks each TLP
// assumes the core holds egress valid until ready
`timescale 1ns/1ps
module egress_stack_model (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic [2:0] i_valid,
  input  wire logic [2:0] i_eop,
  output logic      [2:0] o_ready,
  output logic      [2:0] o_ack
);
  assign o_ready = 3'h7;
  // one ack pulse per finished TLP frees its replay slot
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ack <= 3'h0;
    end else begin
      o_ack <= i_valid & i_eop & o_ready;
    end
  end
endmodule

/* File: switch_core_buffering_bench.sv */
// bench: rows of single-word TLPs from either stack, then TDM and two-word cases
// assumes one core clock and a stack model that always accepts
`timescale 1ns/1ps
module switch_core_buffering_bench;
  typedef struct packed {
    logic up; logic [63:0] d; logic sel; logic [1:0] cls; logic [1:0] dst;
  } row_type;
  logic        i_clk = 1'b0, i_rstn = 1'b0, up_v = 1'b0, dn_v = 1'b0;
  logic        sop = 1'b0, to_b = 1'b0, peer = 1'b0, up_ready, dn_ready;
  logic [63:0] data = 64'h0;
  logic [1:0]  cls = 2'h0;
  logic        eop = 1'b0, tdm = 1'b0;
  logic [11:0] lanes = 12'h444;
  logic [2:0][24:0] stamp;
  logic [2:0]  eg_valid, eg_ready, eg_sop, eg_eop, ack;
  logic [2:0][65:0] eg_data;
  logic [2:0][3:0]  q_full;
  logic [7:0]  adv_hdr, adv_pc, adv_np;
  int          bad_count = 0, compares = 0, cyc = 0, ts = 0;
  row_type     rows [5] = '{
    '{1'b1, 64'h0123456789abcdef, 1'b0, 2'h0, 2'h1},
    '{1'b1, 64'hffffffff00000001, 1'b1, 2'h2, 2'h2},
    '{1'b0, 64'h00000000fffffffe, 1'b0, 2'h1, 2'h0},
    '{1'b0, 64'h8000000080000000, 1'b1, 2'h0, 2'h2},
    '{1'b1, 64'h00000003c0000000, 1'b0, 2'h3, 2'h1}};
  always #5 i_clk = ~i_clk;
  // clocks since release: its low bit is the slot phase, its value the arrival time
  always @(posedge i_clk) cyc <= i_rstn ? cyc + 1 : 0;
  switch_core_buffering u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_up_valid(up_v),
    .o_up_ready(up_ready), .i_up_data(data), .i_up_sop(sop), .i_up_eop(eop),
    .i_up_cls(cls), .i_up_to_b(to_b), .i_dn_valid(dn_v), .o_dn_ready(dn_ready),
    .i_dn_data(data), .i_dn_sop(sop), .i_dn_eop(eop), .i_dn_cls(cls),
    .i_dn_peer(peer), .i_dn_tdm(tdm), .i_lanes(lanes), .o_eg_valid(eg_valid),
    .i_eg_ready(eg_ready), .o_eg_data(eg_data), .o_eg_sop(eg_sop),
    .o_eg_eop(eg_eop), .i_eg_ack(ack), .o_q_full(q_full), .o_head_stamp(stamp),
    .o_adv_hdr(adv_hdr), .o_adv_data_pc(adv_pc), .o_adv_data_np(adv_np));
  egress_stack_model u_stack (.i_clk(i_clk), .i_rstn(i_rstn), .i_valid(eg_valid),
    .i_eop(eg_eop), .o_ready(eg_ready), .o_ack(ack));
  task automatic check(input logic ok, input string what);
    compares++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask
  task automatic xfer(input row_type r);
    int n;
    logic [1:0] dst;
    dst = r.dst;
    @(negedge i_clk);
    {up_v, dn_v, data, cls, to_b, peer, sop, eop} = {r.up, !r.up, r.d, r.cls, r.sel, r.sel, 2'h3};
    for (n = 0; n < 20 && (r.up ? up_ready : dn_ready) !== 1'b1; n++) @(negedge i_clk);
    check(n < 20, "ingress ready");
    // an odd slot belongs to port 4, whose peer is port 2
    if (tdm && r.sel && !r.up && cyc[0]) dst = 2'h1;
    @(negedge i_clk);
    {up_v, dn_v, sop} = 3'h0;
    for (n = 0; n < 30 && eg_valid[dst] !== 1'b1; n++) @(negedge i_clk);
    check(n < switch_core_pkg::LAT_X4_CYC, "latency");
    check(eg_data[dst] === {^r.d[63:32], ^r.d[31:0], r.d}, "egress data");
    check(eg_valid[dst] && eg_sop[dst] && eg_eop[dst], "egress port");
  endtask
  task automatic offer(input logic s, input logic e);
    int n;
    {up_v, sop, eop} = {1'b1, s, e};
    for (n = 0; n < 20 && up_ready !== 1'b1; n++) @(negedge i_clk);
    check(n < 20, "ingress ready");
    ts = cyc;
    @(negedge i_clk);
    up_v = 1'b0;
  endtask
  // two-word TLP port 0 to port 2: egress waits for its end only when ingress is narrower
  task automatic two_word(input logic [11:0] ln, input logic early);
    int n;
    logic seen;
    seen = 1'b0;
    lanes = ln;
    {to_b, cls, data} = {1'b0, 2'h0, 64'h00000000a5a5a5a5};
    @(negedge i_clk);
    offer(1'b1, 1'b0);
    for (n = 0; n < 8; n++) begin
      @(negedge i_clk);
      seen = seen | eg_valid[1];
    end
    check(seen === early, "forwarding mode");
    if (!early) check(stamp[0] === 25'(ts), "arrival stamp");
    offer(1'b0, 1'b1);
    for (n = 0; n < 20 && (eg_valid[1] & eg_eop[1]) !== 1'b1; n++) @(negedge i_clk);
    check(eg_valid[1] === 1'b1 && eg_eop[1] === 1'b1, "tlp end at egress");
  endtask
  task automatic final_report;
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge i_clk);
    i_rstn = 1'b1;
    check(eg_valid === 3'h0 && q_full === 12'h0, "idle after reset");
    check(adv_hdr === 8'h20 && adv_pc === 8'hd0, "credit advert");
    check(adv_np === 8'h20, "nonposted advert");
    foreach (rows[i]) xfer(rows[i]);
    xfer(rows[3]);
    xfer(rows[0]);
    tdm = 1'b1;
    xfer(rows[3]);
    @(negedge i_clk);
    xfer(rows[3]);
    two_word(12'h441, 1'b0);
    two_word(12'h444, 1'b1);
    final_report();
  end
endmodule
